// File: shared/mivp_pkg.sv
package mivp_pkg;
  localparam int unsigned NCH = 8;
  localparam logic [8:0] ADDR_GSTAT = 9'h038;
  localparam logic [8:0] ADDR_PCFG = 9'h039;
  localparam logic [5:0] ADDR_LOW_MASK = 6'h3f;
  localparam int unsigned CH_ADDR_LSB = 6;
  localparam logic [7:0] VEC_SETUP_RST = 8'h00;
  localparam logic [7:0] PORT_CFG_RST = 8'h00;
  localparam logic [7:0] GSTAT_RST = 8'h00;
  localparam int unsigned VS_EXT = 0;
  localparam int unsigned VS_ROT = 1;
  localparam int unsigned PC_DRV0 = 0;
  localparam int unsigned PC_DRV1 = 1;
  localparam int unsigned PC_CHAIN = 2;
  localparam int unsigned PC_SLA_LSB = 3;
  localparam int unsigned PC_SCOPE = 6;
  localparam int unsigned PC_SHOW = 7;
  localparam int unsigned GS_ANY = 3;

  typedef struct packed {
    logic masked_shown;
    logic cycle_scope_sel;
    logic [2:0] cascade_slave_id;
    logic chain_style_sel;
    logic [1:0] irq_drive_cfg;
  } mivp_pcfg_s;

  typedef struct packed {
    logic [1:0] vector_high_bits;
    logic [3:0] ext_bits;
    logic cyclic_priority_en;
    logic vector_ext_select;
  } mivp_vsetup_s;

  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_DRIVE = 2'b01,
    ACK_DONE = 2'b11
  } mivp_ack_e;
endpackage : mivp_pkg

// File: test/mivp_host_model.sv
`timescale 1ns/1ps
module mivp_host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic [7:0] dout,
  input wire logic dout_oe,
  output logic [8:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  output logic ack
);
  initial
  begin
    addr = 9'h000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    ack = 1'b0;
  end

  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    @(posedge clk);
    #1;
    wdata = ~d;
  endtask : wr_reg

  task automatic rd_reg(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    d = rdata;
  endtask : rd_reg

  task automatic ack_cycle(output logic got, output logic [7:0] v);
    got = 1'b0;
    v = 8'h00;
    @(posedge clk);
    #1;
    ack = 1'b1;
    repeat (12)
    begin
      @(posedge clk);
      #1;
      if (!got && dout_oe === 1'b1)
      begin
        got = 1'b1;
        v = dout;
      end
    end
    ack = 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask : ack_cycle
endmodule : mivp_host_model

// File: test/test_multichannel_irq_vector_priority.sv
`timescale 1ns/1ps
module test_multichannel_irq_vector_priority;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] addr;
  logic [7:0] wdata, rdata, dout, rv, v;
  logic wr, rd, ack, dout_oe, irq, irq_oe, en_out, en_oe, got;
  logic [2:0] chain_in = 3'h0;
  logic [2:0] top;
  logic [1:0] dc;
  logic [3:0] pp = 4'h0;
  logic [7:0] st [8];
  logic [7:0] msk [8];
  logic [7:0] view [8];
  logic [31:0] rnd = 32'h42e0;
  int n_errors = 0;
  int n_checks = 0;
  int ch;

  always #20 ref_clk = ~ref_clk;

  mivp_core uut (
    .REF_CLK(ref_clk), .RST_N(rst_n), .CLK_EN(1'b1), .ADDR(addr), .WDATA(wdata),
    .WR_STROBE(wr), .RD_STROBE(rd), .CHAN_STATUS(st), .CHAN_MASK(msk),
    .PORT_PENDING(pp), .ACK_CYCLE(ack), .CHAIN_IN(chain_in), .RDATA(rdata),
    .CHAN_VIEW(view), .DATA_OUT(dout), .DATA_OE(dout_oe), .IRQ_OUT(irq), .IRQ_OE(irq_oe),
    .CHAIN_EN_OUT(en_out), .CHAIN_EN_OE(en_oe), .TOP_CHANNEL(top)
  );

  mivp_host_model host (
    .clk(ref_clk), .rdata(rdata), .dout(dout), .dout_oe(dout_oe), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .ack(ack)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Bench model of the status register
  function automatic logic [7:0] gstat(input logic [3:0] p, input int c);
    return {p[0], p[1], p[2], p[3], c >= 0, c >= 0 ? 3'(c) : 3'h0};
  endfunction : gstat

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
    n_checks++;
    if ((g & m) !== (e & m))
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Channels set in on have only bit 0 unmasked, all others carry fully masked status
  task automatic only(input logic [7:0] on);
    rnd = lfsr(rnd);
    foreach (st[k])
    begin
      st[k] = rnd[7:0] | 8'h01;
      msk[k] = on[k] ? 8'hfe : 8'hff;
    end
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : only

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  initial
  begin
    #2000000;
    n_errors++;
    stop_test();
  end

  initial
  begin
    foreach (st[k])
    begin
      st[k] = 8'h00;
      msk[k] = 8'hff;
    end
    repeat (20) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    host.rd_reg(mivp_pkg::ADDR_GSTAT, rv);
    chk(rv, mivp_pkg::GSTAT_RST, 8'hff);
    host.rd_reg(mivp_pkg::ADDR_PCFG, rv);
    chk(rv, mivp_pkg::PORT_CFG_RST, 8'hff);
    for (int c = 0; c < 8; c++)
    begin
      rnd = lfsr(rnd);
      host.wr_reg({3'(c), 6'h38}, 8'h00);
      chk({5'h00, top}, 8'(c), 8'hff);
      host.wr_reg({3'(c), 6'h39}, rnd[7:0]);
      host.rd_reg({3'(7 - c), 6'h39}, rv);
      chk(rv, rnd[7:0], 8'hff);
    end
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      ch = int'(rnd[6:4]);
      pp = rnd[11:8];
      host.wr_reg(mivp_pkg::ADDR_PCFG, {i[0], 7'h01});
      only(8'h01 << ch);
      host.rd_reg({3'(i), 6'h38}, rv);
      chk(rv, gstat(pp, ch), 8'hff);
      chk(view[ch], i[0] ? st[ch] : 8'h01, 8'hff);
      chk(view[(ch + 1) % 8], i[0] ? st[(ch + 1) % 8] : 8'h00, 8'hff);
      chk({6'h00, irq_oe, irq}, 8'h02, 8'hff);
    end
    only(8'h00);
    host.rd_reg(mivp_pkg::ADDR_GSTAT, rv);
    chk(rv, gstat(pp, -1), 8'hf8);
    for (int j = 0; j < 6; j++)
    begin
      dc = j < 4 ? 2'(j / 2) : 2'b11;
      host.wr_reg(mivp_pkg::ADDR_PCFG, {6'h00, dc});
      only({7'h00, j[0]});
      chk({6'h00, irq_oe, irq}, {6'h00, j[0] | dc[0], dc[0] & (dc[1] == j[0])},
        {6'h00, 1'b1, j[0] | dc[0]});
    end
    host.wr_reg(mivp_pkg::ADDR_PCFG, 8'h29);
    host.wr_reg(9'h0b8, 8'h99);
    chain_in = 3'd5;
    only(8'h08);
    host.ack_cycle(got, v);
    chk({got, v[7:1]}, 8'hcc, 8'hfe);
    only(8'h20);
    host.rd_reg(mivp_pkg::ADDR_GSTAT, rv);
    chk(rv, gstat(pp, 3), 8'hff);
    host.rd_reg(mivp_pkg::ADDR_GSTAT, rv);
    chk(rv, gstat(pp, 5), 8'hff);
    host.wr_reg(9'h0b8, 8'h40);
    host.ack_cycle(got, v);
    chk(v, 8'h54, 8'hfc);
    chain_in = 3'd2;
    host.ack_cycle(got, v);
    chk({7'h00, got}, 8'h00, 8'hff);
    host.wr_reg(mivp_pkg::ADDR_PCFG, 8'h05);
    chain_in = 3'd0;
    only(8'h20);
    chk({6'h00, en_oe, en_out}, 8'h02, 8'hff);
    host.ack_cycle(got, v);
    chk({7'h00, got}, 8'h01, 8'hff);
    chain_in = 3'd2;
    host.ack_cycle(got, v);
    chk({7'h00, got}, 8'h00, 8'hff);
    chain_in = 3'd0;
    for (int s = 0; s < 2; s++)
    begin
      host.wr_reg(mivp_pkg::ADDR_PCFG, s == 0 ? 8'h01 : 8'h41);
      host.wr_reg(9'h178, 8'h00);
      only(8'h24);
      host.rd_reg(mivp_pkg::ADDR_GSTAT, rv);
      chk(rv, gstat(pp, 5), 8'hff);
      host.wr_reg(9'h178, 8'h02);
      host.ack_cycle(got, v);
      host.rd_reg(mivp_pkg::ADDR_GSTAT, rv);
      chk(rv, gstat(pp, s == 0 ? 2 : 5), 8'hff);
      host.rd_reg(mivp_pkg::ADDR_GSTAT, rv);
      chk(rv, gstat(pp, 5), 8'hff);
    end
    stop_test();
  end
endmodule : test_multichannel_irq_vector_priority

// File: verilog/mivp_core.sv
`timescale 1ns/1ps
module mivp_core (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic [8:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_STROBE,
  input wire logic RD_STROBE,
  input wire logic [7:0] CHAN_STATUS [8],
  input wire logic [7:0] CHAN_MASK [8],
  input wire logic [3:0] PORT_PENDING,
  input wire logic ACK_CYCLE,
  input wire logic [2:0] CHAIN_IN,
  output logic [7:0] RDATA,
  output logic [7:0] CHAN_VIEW [8],
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  output logic IRQ_OUT,
  output logic IRQ_OE,
  output logic CHAIN_EN_OUT,
  output logic CHAIN_EN_OE,
  output logic [2:0] TOP_CHANNEL
);
  logic [2:0] chain_s1_q;
  logic [2:0] chain_s2_q;
  logic [3:0] port_s1_q;
  logic [3:0] port_s2_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic [7:0] src_s1_q [8];
  logic [7:0] src_s2_q [8];
  mivp_pkg::mivp_vsetup_s vs_q;
  mivp_pkg::mivp_vsetup_s vs_d;
  mivp_pkg::mivp_pcfg_s pc_q;
  mivp_pkg::mivp_pcfg_s pc_d;
  logic [2:0] top_q;
  logic [2:0] top_d;
  logic [2:0] last_q;
  logic [2:0] last_d;
  logic [7:0] gstat_q;
  logic [7:0] gstat_d;
  logic frozen_q;
  logic frozen_d;
  logic wr_q;
  logic wr_d;
  logic [8:0] wr_addr_q;
  logic [8:0] wr_addr_d;
  logic [7:0] wr_data_q;
  logic [7:0] wr_data_d;
  mivp_pkg::mivp_ack_e ack_q;
  mivp_pkg::mivp_ack_e ack_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] dout_q;
  logic [7:0] dout_d;
  logic doe_q;
  logic doe_d;
  logic irq_q;
  logic irq_d;
  logic irqoe_q;
  logic irqoe_d;
  logic chout_q;
  logic chout_d;
  logic [7:0] chan_act;
  logic any_act;
  logic [2:0] winner;
  logic req;
  logic ack_ok;
  logic ack_rise;
  logic is_gstat;
  logic is_pcfg;
  logic [2:0] seq_idx;
  logic [2:0] cand;
  logic found;

  function automatic logic sel_reg(input logic [8:0] a, input logic [8:0] base);
    sel_reg = (a[5:0] & mivp_pkg::ADDR_LOW_MASK) == base[5:0];
  endfunction : sel_reg

  // Synchronisers for foreign inputs
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      chain_s1_q <= 3'h0;
      chain_s2_q <= 3'h0;
      port_s1_q <= 4'h0;
      port_s2_q <= 4'h0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
        src_s1_q[i] <= 8'h00;
        src_s2_q[i] <= 8'h00;
      end
    end
    else if (CLK_EN)
    begin
      chain_s1_q <= CHAIN_IN;
      chain_s2_q <= chain_s1_q;
      port_s1_q <= PORT_PENDING;
      port_s2_q <= port_s1_q;
      ack_s1_q <= ACK_CYCLE;
      ack_s2_q <= ack_s1_q;
      for (int i = 0; i < 8; i++)
      begin
        src_s1_q[i] <= CHAN_STATUS[i] & ~CHAN_MASK[i];
        src_s2_q[i] <= src_s1_q[i];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_act
      assign chan_act[g] = |src_s2_q[g];
      always_ff @(posedge REF_CLK or negedge RST_N)
      begin
        if (!RST_N)
          CHAN_VIEW[g] <= 8'h00;
        else if (CLK_EN)
          CHAN_VIEW[g] <= pc_q.masked_shown ? CHAN_STATUS[g] : (CHAN_STATUS[g] & ~CHAN_MASK[g]);
      end
    end
  endgenerate

  assign any_act = |chan_act;
  assign is_gstat = sel_reg(ADDR, mivp_pkg::ADDR_GSTAT);
  assign is_pcfg = sel_reg(ADDR, mivp_pkg::ADDR_PCFG);
  assign ack_rise = ack_s2_q && (ack_q == mivp_pkg::ACK_IDLE);
  assign req = any_act;
  assign ack_ok = pc_q.chain_style_sel ? (req && !chain_s2_q[1])
                                       : (req && chain_s2_q == pc_q.cascade_slave_id);

  always_comb
  begin
    winner = 3'h0;
    found = 1'b0;
    cand = 3'h0;
    seq_idx = 3'h0;
    if (!vs_q.cyclic_priority_en || pc_q.cycle_scope_sel)
    begin
      if (chan_act[top_q])
      begin
        winner = top_q;
        found = 1'b1;
      end
    end
    for (int k = 1; k < 9; k++)
    begin
      if (!vs_q.cyclic_priority_en)
        cand = 3'(top_q + 3'(k));
      else if (!pc_q.cycle_scope_sel)
        cand = 3'(last_q + 3'(k));
      else
      begin
        seq_idx = 3'(last_q + 3'(k));
        cand = seq_idx;
      end
      if (!found && chan_act[cand] && !(vs_q.cyclic_priority_en && pc_q.cycle_scope_sel
                                           && cand == top_q))
      begin
        winner = cand;
        found = 1'b1;
      end
    end
  end

  always_comb
  begin
    vs_d = vs_q;
    pc_d = pc_q;
    top_d = top_q;
    last_d = last_q;
    wr_d = WR_STROBE;
    wr_addr_d = WR_STROBE ? ADDR : wr_addr_q;
    wr_data_d = WR_STROBE ? WDATA : wr_data_q;
    gstat_d = gstat_q;
    frozen_d = frozen_q;
    ack_d = ack_q;
    rdata_d = rdata_q;
    dout_d = dout_q;
    doe_d = 1'b0;
    if (wr_q && !WR_STROBE)
    begin
      if (sel_reg(wr_addr_q, mivp_pkg::ADDR_GSTAT))
      begin
        vs_d = wr_data_q;
        top_d = wr_addr_q[8:mivp_pkg::CH_ADDR_LSB];
      end
      else if (sel_reg(wr_addr_q, mivp_pkg::ADDR_PCFG))
        pc_d = wr_data_q;
    end
    if (!frozen_q)
      gstat_d = {port_s2_q[0], port_s2_q[1], port_s2_q[2], port_s2_q[3], any_act,
                 any_act ? winner : 3'h0};
    if (RD_STROBE)
    begin
      if (is_gstat)
      begin
        rdata_d = gstat_q;
        frozen_d = 1'b0;
      end
      else if (is_pcfg)
        rdata_d = pc_q;
      else
        rdata_d = 8'h00;
    end
    unique case (ack_q)
      mivp_pkg::ACK_IDLE:
      begin
        if (ack_rise && ack_ok)
        begin
          frozen_d = 1'b1;
          gstat_d = gstat_q;
          ack_d = mivp_pkg::ACK_DRIVE;
          last_d = gstat_q[2:0];
        end
        else if (ack_rise)
          ack_d = mivp_pkg::ACK_DONE;
      end
      mivp_pkg::ACK_DRIVE:
      begin
        dout_d = {vs_q.vector_high_bits,
                  vs_q.vector_ext_select ? vs_q.ext_bits : {1'b0, gstat_q[2:0]}, 2'b00};
        doe_d = 1'b1;
        if (!ack_s2_q)
          ack_d = mivp_pkg::ACK_IDLE;
      end
      mivp_pkg::ACK_DONE:
      begin
        if (!ack_s2_q)
          ack_d = mivp_pkg::ACK_IDLE;
      end
      default: ack_d = mivp_pkg::ACK_IDLE;
    endcase
  end

  always_comb
  begin
    irq_d = pc_q.irq_drive_cfg[0] ? (req ~^ pc_q.irq_drive_cfg[1]) ? 1'b1 : 1'b0 : 1'b0;
    if (pc_q.irq_drive_cfg[0])
      irq_d = pc_q.irq_drive_cfg[1] ? req : !req;
    irqoe_d = pc_q.irq_drive_cfg[0] ? 1'b1 : req;
    chout_d = !(req || chain_s2_q[1]);
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      vs_q <= mivp_pkg::VEC_SETUP_RST;
      pc_q <= mivp_pkg::PORT_CFG_RST;
      top_q <= 3'h0;
      last_q <= 3'h7;
      gstat_q <= mivp_pkg::GSTAT_RST;
      frozen_q <= 1'b0;
      wr_q <= 1'b0;
      wr_addr_q <= 9'h000;
      wr_data_q <= 8'h00;
      ack_q <= mivp_pkg::ACK_IDLE;
      rdata_q <= 8'h00;
      dout_q <= 8'h00;
      doe_q <= 1'b0;
      irq_q <= 1'b0;
      irqoe_q <= 1'b0;
      chout_q <= 1'b1;
    end
    else if (CLK_EN)
    begin
      vs_q <= vs_d;
      pc_q <= pc_d;
      top_q <= top_d;
      last_q <= last_d;
      gstat_q <= gstat_d;
      frozen_q <= frozen_d;
      wr_q <= wr_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      irq_q <= irq_d;
      irqoe_q <= irqoe_d;
      chout_q <= chout_d;
    end
  end

  assign RDATA = rdata_q;
  assign DATA_OUT = dout_q;
  assign DATA_OE = doe_q;
  assign IRQ_OUT = irq_q;
  assign IRQ_OE = irqoe_q;
  assign CHAIN_EN_OUT = chout_q;
  assign CHAIN_EN_OE = pc_q.chain_style_sel;
  assign TOP_CHANNEL = top_q;

  property p_top_sel;
    @(posedge REF_CLK) disable iff (!RST_N)
    (CLK_EN && wr_q && !WR_STROBE && sel_reg(wr_addr_q, mivp_pkg::ADDR_GSTAT))
      |=> (top_q == $past(wr_addr_q[8:6]));
  endproperty
  a_top_sel: assert property (p_top_sel) else $error("top channel not taken");
  property p_any;
    @(posedge REF_CLK) disable iff (!RST_N)
    (CLK_EN && !frozen_q && !(ack_rise && ack_ok)) |=> (gstat_q[mivp_pkg::GS_ANY] == $past(any_act));
  endproperty
  a_any: assert property (p_any) else $error("channel flag wrong");
  property p_freeze;
    @(posedge REF_CLK) disable iff (!RST_N)
    (CLK_EN && frozen_q && !RD_STROBE) |=> $stable(gstat_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("status changed while frozen");
  property p_vec;
    @(posedge REF_CLK) disable iff (!RST_N)
    DATA_OE |-> DATA_OUT[7:6] == vs_q.vector_high_bits;
  endproperty
  a_vec: assert property (p_vec) else $error("vector top bits wrong");
  property p_ext;
    @(posedge REF_CLK) disable iff (!RST_N)
    (DATA_OE && vs_q.vector_ext_select) |-> DATA_OUT[5:2] == vs_q.ext_bits;
  endproperty
  a_ext: assert property (p_ext) else $error("extended bits wrong");
  property p_chain;
    @(posedge REF_CLK) disable iff (!RST_N)
    (CLK_EN && req) |=> !CHAIN_EN_OUT;
  endproperty
  a_chain: assert property (p_chain) else $error("enable out not low");
  property p_pp;
    @(posedge REF_CLK) disable iff (!RST_N)
    (CLK_EN && pc_q.irq_drive_cfg == 2'b01 && $stable(pc_q)) |=> (IRQ_OUT == !$past(req));
  endproperty
  a_pp: assert property (p_pp) else $error("push-pull low level wrong");
  property p_fixed;
    @(posedge REF_CLK) disable iff (!RST_N)
    (!vs_q.cyclic_priority_en && chan_act[top_q]) |-> winner == top_q;
  endproperty
  a_fixed: assert property (p_fixed) else $error("top channel not first");
  c_ack: cover property (@(posedge REF_CLK) disable iff (!RST_N) DATA_OE);
  c_rot: cover property (@(posedge REF_CLK) disable iff (!RST_N)
    vs_q.cyclic_priority_en && ack_rise && ack_ok);
  c_wr: cover property (@(posedge REF_CLK) disable iff (!RST_N) wr_q && !WR_STROBE);
endmodule : mivp_core
